// >>> ifc_pkg.sv
package ifc_pkg;

  localparam logic [6:0] IFC_DEPTH      = 7'h40;
  localparam logic [7:0] IFC_RX_FILL_TRIGGER_MAX  = 8'h3F;
  localparam int         IFC_IRQ_W      = 12;
  localparam int         IFC_CAUSE_W    = 17;

  localparam logic [7:0] IFC_OFS_RX_FILL_TRIGGER        = 8'h38;
  localparam logic [7:0] IFC_OFS_TX_DRAIN_TRIGGER        = 8'h3C;
  localparam logic [7:0] IFC_OFS_CLR_ALL      = 8'h40;
  localparam logic [7:0] IFC_OFS_CLR_RX_UNDER = 8'h44;
  localparam logic [7:0] IFC_OFS_CLR_RX_OVER  = 8'h48;
  localparam logic [7:0] IFC_OFS_CLR_TX_OVER  = 8'h4C;
  localparam logic [7:0] IFC_OFS_CLR_RD_REQ   = 8'h50;
  localparam logic [7:0] IFC_OFS_CLR_TX_ABORT = 8'h54;
  localparam logic [7:0] IFC_OFS_CLR_RX_DONE  = 8'h58;
  localparam logic [7:0] IFC_OFS_CLR_ACTIVITY = 8'h5C;
  localparam logic [7:0] IFC_OFS_CLR_STOP     = 8'h60;
  localparam logic [7:0] IFC_OFS_CLR_START    = 8'h64;
  localparam logic [7:0] IFC_OFS_CLR_GENERAL_CALL_IRQ = 8'h68;
  localparam logic [7:0] IFC_OFS_ENABLE       = 8'h6C;
  localparam logic [7:0] IFC_OFS_STATUS       = 8'h70;
  localparam logic [7:0] IFC_OFS_TX_ENTRY_COUNT        = 8'h74;
  localparam logic [7:0] IFC_OFS_RX_ENTRY_COUNT        = 8'h78;

  localparam int IFC_IRQ_RX_UNDER = 0;
  localparam int IFC_IRQ_RX_OVER  = 1;
  localparam int IFC_IRQ_RX_FULL  = 2;
  localparam int IFC_IRQ_TX_OVER  = 3;
  localparam int IFC_IRQ_TX_EMPTY = 4;
  localparam int IFC_IRQ_RD_REQ   = 5;
  localparam int IFC_IRQ_TX_ABORT = 6;
  localparam int IFC_IRQ_RX_DONE  = 7;
  localparam int IFC_IRQ_ACTIVITY = 8;
  localparam int IFC_IRQ_STOP     = 9;
  localparam int IFC_IRQ_START    = 10;
  localparam int IFC_IRQ_GENERAL_CALL_IRQ = 11;

  localparam int IFC_EN_BIT     = 0;
  localparam int IFC_ABORT_BIT  = 1;
  localparam int IFC_SBYTE_BIT  = 9;

  localparam int IFC_ST_BUSY = 0;
  localparam int IFC_ST_TX_NOT_FULL_FLAG = 1;
  localparam int IFC_ST_TFE  = 2;
  localparam int IFC_ST_RX_NOT_EMPTY_FLAG = 3;
  localparam int IFC_ST_RFF  = 4;
  localparam int IFC_ST_MST  = 5;
  localparam int IFC_ST_SLV  = 6;

  localparam logic [7:0] IFC_RST_TL     = 8'h00;
  localparam logic       IFC_RST_ENABLE = 1'b0;

  typedef enum logic [0:0] {
    IFC_BUS_IDLE = 1'b0,
    IFC_BUS_BUSY = 1'b1
  } ifc_bus_e;

  typedef struct packed {
    logic                   tx_push;
    logic                   tx_pop;
    logic                   rx_push;
    logic                   rx_pop;
    logic                   rd_req;
    logic                   rx_done;
    logic                   general_call_irq;
    logic                   abort;
    logic [IFC_CAUSE_W-1:0] abort_why;
    logic                   sbyte_cond;
    logic                   master_busy;
    logic                   slave_busy;
  } ifc_evt_t;

  typedef struct packed {
    logic                   en;
    logic                   abort_req;
    logic [7:0]             rx_fill_trigger;
    logic [7:0]             tx_drain_trigger;
    logic [6:0]             tx_cnt;
    logic [6:0]             rx_cnt;
    logic [IFC_IRQ_W-1:0]   irq;
    logic [IFC_CAUSE_W-1:0] cause;
    logic                   sbyte_rearm;
    logic                   scl_s1;
    logic                   scl_s2;
    logic                   scl_q;
    logic                   sda_s1;
    logic                   sda_s2;
    logic                   sda_q;
    ifc_bus_e               bus;
    logic [31:0]            rdata;
  } ifc_st_t;

endpackage

// >>> ifc_ctrl.sv
// Functional notes
// - Receive level irq at threshold plus one entries.
// - Receive threshold above 0x3F stores buffer depth.
// - Transmit level irq when enabled and count at/below threshold; disabled, follows activity.
// - Transmit threshold above depth stores depth.
// - Combined clear read clears soft irqs, cause.
// - Start-byte cause drops one cycle, then reasserts.
// - Read 44h clears receive underflow, bit 0.
// - Read 48h clears receive overflow, bit 1.
// - Read 4Ch clears transmit overflow, bit 3.
// - Read 50h clears read request, bit 5.
// - Read 54h clears abort, cause, releases transmit.
// - Read 58h clears receive done, bit 7.
// - Activity cleared by read only when idle.
// - Reads 60h/64h clear stop and start irqs.
// - Read 68h clears general call, bit 11.
// - Abort bit self-clears when stop is seen.
// - Disabled holds FIFOs flushed; irqs live until idle.
// - Disable: finish transmit, nack last received byte.
// - Disable sets status 1,2; clears 3,4; 5,6 follow busy inputs.
// - Status 4 full, status 3 not empty.
// - Status 2 empty, 1 not full; reset one.
// - Status 5 master busy, 0 overall activity.
// - Transmit level register reports entry count.
`timescale 1ns/10ps
module ifc_ctrl (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  output logic      [31:0]                   reg_rdata,
  input  wire logic                          scl_pin,
  input  wire logic                          sda_pin,
  input  wire ifc_pkg::ifc_evt_t             evt,
  output logic                               tx_accept,
  output logic                               ctrl_enabled,
  output logic                               nack_last_byte,
  output logic                               abort_request,
  output logic      [ifc_pkg::IFC_IRQ_W-1:0] unmasked_irq_status,
  output logic      [31:0]                   abort_cause_reg,
  output logic      [6:0]                    tx_entry_count,
  output logic      [6:0]                    rx_entry_count
);
  import ifc_pkg::*;

  ifc_st_t              st;
  ifc_st_t              next_st;
  logic                 start_seen_irq;
  logic                 stop_seen_irq;
  logic                 ctrl_busy;
  logic                 idle_off;
  logic                 tx_full;
  logic                 rx_full;
  logic                 tx_ok;
  logic                 clr_cause;
  logic [IFC_IRQ_W-1:0] raw_irq;
  logic [IFC_IRQ_W-1:0] set_irq;
  logic [IFC_IRQ_W-1:0] clr_irq;
  logic [31:0]          status_word;
  logic [31:0]          read_word;

  function automatic logic [7:0] clamp_tl(input logic [7:0] v, input logic [7:0] lim);
    return (v > lim) ? {1'b0, IFC_DEPTH} : v;
  endfunction

  function automatic logic rd_at(input logic rd, input logic [7:0] a, input logic [7:0] ofs);
    return rd && (a == ofs);
  endfunction

  // Bus conditions are taken from the second synchroniser stage onward only.
  assign start_seen_irq = st.scl_s2 && st.scl_q && st.sda_q && !st.sda_s2;
  assign stop_seen_irq  = st.scl_s2 && st.scl_q && !st.sda_q && st.sda_s2;
  assign ctrl_busy = evt.master_busy | evt.slave_busy | (st.bus == IFC_BUS_BUSY);
  assign idle_off  = !st.en && !ctrl_busy;
  assign tx_full   = (st.tx_cnt == IFC_DEPTH);
  assign rx_full   = (st.rx_cnt == IFC_DEPTH);
  // Transmit pushes are refused while disabled or while the abort holds the FIFO flushed.
  assign tx_ok     = st.en && !st.irq[IFC_IRQ_TX_ABORT] && !tx_full;
  assign clr_cause = rd_at(reg_rd, reg_addr, IFC_OFS_CLR_ALL)
                   | rd_at(reg_rd, reg_addr, IFC_OFS_CLR_TX_ABORT);

  always_comb begin
    raw_irq = st.irq;
    raw_irq[IFC_IRQ_RX_FULL] = st.en && ({1'b0, st.rx_cnt} > st.rx_fill_trigger);
    // While disabled the flushed FIFO looks empty, so the bit follows activity.
    raw_irq[IFC_IRQ_TX_EMPTY] = st.en ? ({1'b0, st.tx_cnt} <= st.tx_drain_trigger) : ctrl_busy;
  end

  always_comb begin
    set_irq = '0;
    set_irq[IFC_IRQ_RX_UNDER] = st.en && evt.rx_pop && (st.rx_cnt == 7'h00);
    set_irq[IFC_IRQ_RX_OVER]  = st.en && evt.rx_push && rx_full;
    set_irq[IFC_IRQ_TX_OVER]  = st.en && evt.tx_push && tx_full && !st.irq[IFC_IRQ_TX_ABORT];
    set_irq[IFC_IRQ_RD_REQ]   = evt.rd_req;
    set_irq[IFC_IRQ_TX_ABORT] = evt.abort;
    set_irq[IFC_IRQ_RX_DONE]  = evt.rx_done;
    set_irq[IFC_IRQ_ACTIVITY] = ctrl_busy;
    set_irq[IFC_IRQ_STOP]     = stop_seen_irq;
    set_irq[IFC_IRQ_START]    = start_seen_irq;
    set_irq[IFC_IRQ_GENERAL_CALL_IRQ] = evt.general_call_irq;
  end

  // Each read clear acts in the single cycle that carries the read strobe.
  always_comb begin
    clr_irq = {IFC_IRQ_W{rd_at(reg_rd, reg_addr, IFC_OFS_CLR_ALL)}};
    clr_irq[IFC_IRQ_RX_FULL]  = 1'b0;
    clr_irq[IFC_IRQ_TX_EMPTY] = 1'b0;
    clr_irq[IFC_IRQ_RX_UNDER] |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_RX_UNDER);
    clr_irq[IFC_IRQ_RX_OVER]  |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_RX_OVER);
    clr_irq[IFC_IRQ_TX_OVER]  |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_TX_OVER);
    clr_irq[IFC_IRQ_RD_REQ]   |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_RD_REQ);
    clr_irq[IFC_IRQ_TX_ABORT] |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_TX_ABORT);
    clr_irq[IFC_IRQ_RX_DONE]  |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_RX_DONE);
    clr_irq[IFC_IRQ_ACTIVITY] |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_ACTIVITY);
    clr_irq[IFC_IRQ_STOP]     |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_STOP);
    clr_irq[IFC_IRQ_START]    |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_START);
    clr_irq[IFC_IRQ_GENERAL_CALL_IRQ] |= rd_at(reg_rd, reg_addr, IFC_OFS_CLR_GENERAL_CALL_IRQ);
    // Disabled and idle drops every latched event, activity included.
    if (idle_off) begin
      clr_irq = '1;
    end
  end

  always_comb begin
    status_word = '0;
    status_word[IFC_ST_BUSY] = ctrl_busy;
    status_word[IFC_ST_TX_NOT_FULL_FLAG] = !tx_full;
    status_word[IFC_ST_TFE]  = (st.tx_cnt == 7'h00);
    status_word[IFC_ST_RX_NOT_EMPTY_FLAG] = (st.rx_cnt != 7'h00);
    status_word[IFC_ST_RFF]  = rx_full;
    status_word[IFC_ST_MST]  = evt.master_busy;
    status_word[IFC_ST_SLV]  = evt.slave_busy;
  end

  always_comb begin
    read_word = '0;
    case (reg_addr)
      IFC_OFS_RX_FILL_TRIGGER:        read_word[7:0] = st.rx_fill_trigger;
      IFC_OFS_TX_DRAIN_TRIGGER:        read_word[7:0] = st.tx_drain_trigger;
      IFC_OFS_CLR_ALL:      read_word[0] = |raw_irq;
      IFC_OFS_CLR_RX_UNDER: read_word[0] = raw_irq[IFC_IRQ_RX_UNDER];
      IFC_OFS_CLR_RX_OVER:  read_word[0] = raw_irq[IFC_IRQ_RX_OVER];
      IFC_OFS_CLR_TX_OVER:  read_word[0] = raw_irq[IFC_IRQ_TX_OVER];
      IFC_OFS_CLR_RD_REQ:   read_word[0] = raw_irq[IFC_IRQ_RD_REQ];
      IFC_OFS_CLR_TX_ABORT: read_word[0] = raw_irq[IFC_IRQ_TX_ABORT];
      IFC_OFS_CLR_RX_DONE:  read_word[0] = raw_irq[IFC_IRQ_RX_DONE];
      IFC_OFS_CLR_ACTIVITY: read_word[0] = raw_irq[IFC_IRQ_ACTIVITY];
      IFC_OFS_CLR_STOP:     read_word[0] = raw_irq[IFC_IRQ_STOP];
      IFC_OFS_CLR_START:    read_word[0] = raw_irq[IFC_IRQ_START];
      IFC_OFS_CLR_GENERAL_CALL_IRQ: read_word[0] = raw_irq[IFC_IRQ_GENERAL_CALL_IRQ];
      IFC_OFS_ENABLE:       read_word[1:0] = {st.abort_req, st.en};
      IFC_OFS_STATUS:       read_word = status_word;
      IFC_OFS_TX_ENTRY_COUNT:        read_word[6:0] = st.tx_cnt;
      IFC_OFS_RX_ENTRY_COUNT:        read_word[6:0] = st.rx_cnt;
      default:              read_word = '0;
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.scl_s1 = scl_pin;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_q  = st.scl_s2;
    next_st.sda_s1 = sda_pin;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_q  = st.sda_s2;
    case (st.bus)
      IFC_BUS_IDLE: begin
        if (start_seen_irq) begin
          next_st.bus = IFC_BUS_BUSY;
        end
      end
      IFC_BUS_BUSY: begin
        if (stop_seen_irq) begin
          next_st.bus = IFC_BUS_IDLE;
        end
      end
      default: next_st.bus = IFC_BUS_IDLE;
    endcase

    if (reg_wr && (reg_addr == IFC_OFS_RX_FILL_TRIGGER)) begin
      next_st.rx_fill_trigger = clamp_tl(reg_wdata[7:0], IFC_RX_FILL_TRIGGER_MAX);
    end
    if (reg_wr && (reg_addr == IFC_OFS_TX_DRAIN_TRIGGER)) begin
      next_st.tx_drain_trigger = clamp_tl(reg_wdata[7:0], {1'b0, IFC_DEPTH});
    end
    if (reg_wr && (reg_addr == IFC_OFS_ENABLE)) begin
      next_st.en        = reg_wdata[IFC_EN_BIT];
      next_st.abort_req = reg_wdata[IFC_ABORT_BIT];
    end else if (stop_seen_irq) begin
      next_st.abort_req = 1'b0;
    end

    // Sticky events: a set in the same cycle as its clear wins.
    next_st.irq = (st.irq & ~clr_irq) | set_irq;
    next_st.irq[IFC_IRQ_RX_FULL]  = 1'b0;
    next_st.irq[IFC_IRQ_TX_EMPTY] = 1'b0;

    // The link side stops on its own when disabled; the counts flush in the same
    // update that clears the enable bit, so status never shows stale levels.
    if (!next_st.en) begin
      next_st.tx_cnt = 7'h00;
      next_st.rx_cnt = 7'h00;
    end else begin
      if (st.irq[IFC_IRQ_TX_ABORT] || set_irq[IFC_IRQ_TX_ABORT]) begin
        next_st.tx_cnt = 7'h00;
      end else begin
        next_st.tx_cnt = st.tx_cnt + 7'(evt.tx_push && tx_ok)
                       - 7'(evt.tx_pop && (st.tx_cnt != 7'h00));
      end
      next_st.rx_cnt = st.rx_cnt + 7'(evt.rx_push && !rx_full)
                     - 7'(evt.rx_pop && (st.rx_cnt != 7'h00));
    end

    // Clearing the cause while the start-byte fault persists rearms that bit.
    next_st.sbyte_rearm = 1'b0;
    if (clr_cause) begin
      next_st.cause       = evt.abort ? evt.abort_why : '0;
      next_st.sbyte_rearm = st.cause[IFC_SBYTE_BIT] && evt.sbyte_cond;
    end else begin
      next_st.cause = st.cause | (evt.abort ? evt.abort_why : '0);
      if (st.sbyte_rearm && evt.sbyte_cond) begin
        next_st.cause[IFC_SBYTE_BIT] = 1'b1;
      end
    end

    if (reg_rd) begin
      next_st.rdata = read_word;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata           = st.rdata;
  assign tx_accept           = tx_ok;
  assign ctrl_enabled        = st.en;
  assign nack_last_byte      = !st.en;
  assign abort_request       = st.abort_req;
  assign unmasked_irq_status = raw_irq;
  assign abort_cause_reg     = {{(32 - IFC_CAUSE_W){1'b0}}, st.cause};
  assign tx_entry_count      = st.tx_cnt;
  assign rx_entry_count      = st.rx_cnt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sbyte_clear;
    clr_cause && !evt.abort && st.cause[IFC_SBYTE_BIT] && evt.sbyte_cond;
  endsequence

  sequence s_sbyte_persist;
    evt.sbyte_cond;
  endsequence

  a_rx_level_irq: assert property (
    unmasked_irq_status[IFC_IRQ_RX_FULL] == (st.en && ({1'b0, rx_entry_count} >= st.rx_fill_trigger + 8'h01))
  ) else $error("receive level irq mismatch");

  a_rx_fill_trigger_clamp: assert property (
    reg_wr && (reg_addr == IFC_OFS_RX_FILL_TRIGGER) && (reg_wdata[7:0] > IFC_RX_FILL_TRIGGER_MAX)
    |=> st.rx_fill_trigger == {1'b0, IFC_DEPTH}
  ) else $error("receive threshold not clamped");

  a_tx_level_irq: assert property (
    st.en && ({1'b0, tx_entry_count} <= st.tx_drain_trigger) |-> unmasked_irq_status[IFC_IRQ_TX_EMPTY]
  ) else $error("transmit level irq missing");

  a_tx_drain_trigger_clamp: assert property (
    reg_wr && (reg_addr == IFC_OFS_TX_DRAIN_TRIGGER) && (reg_wdata[7:0] > {1'b0, IFC_DEPTH})
    |=> st.tx_drain_trigger == {1'b0, IFC_DEPTH}
  ) else $error("transmit threshold not clamped");

  a_clear_all_read: assert property (
    rd_at(reg_rd, reg_addr, IFC_OFS_CLR_ALL) && !evt.abort && !evt.rx_done && st.en
    |=> (abort_cause_reg == 32'h0000_0000) && !unmasked_irq_status[IFC_IRQ_RX_DONE]
  ) else $error("combined clear did not clear");

  a_sbyte_rearm: assert property (
    s_sbyte_clear ##1 s_sbyte_persist |-> !st.cause[IFC_SBYTE_BIT] ##1 st.cause[IFC_SBYTE_BIT]
  ) else $error("start byte cause not rearmed after one cycle");

  a_underflow_clear: assert property (
    rd_at(reg_rd, reg_addr, IFC_OFS_CLR_RX_UNDER) && !set_irq[IFC_IRQ_RX_UNDER]
    |=> !unmasked_irq_status[IFC_IRQ_RX_UNDER]
  ) else $error("underflow not cleared");

  a_abort_release: assert property (
    rd_at(reg_rd, reg_addr, IFC_OFS_CLR_TX_ABORT) && !evt.abort && st.en && !reg_wr
    |=> !unmasked_irq_status[IFC_IRQ_TX_ABORT] && (tx_accept == (tx_entry_count != IFC_DEPTH))
  ) else $error("abort clear did not release transmit");

  a_abort_self_clear: assert property (
    st.abort_req && stop_seen_irq && !(reg_wr && (reg_addr == IFC_OFS_ENABLE)) |=> !abort_request
  ) else $error("abort bit held after stop");

  a_disable_status: assert property (
    !st.en |-> (status_word[IFC_ST_TFE:IFC_ST_TX_NOT_FULL_FLAG] == 2'b11)
           && (status_word[IFC_ST_RFF:IFC_ST_RX_NOT_EMPTY_FLAG] == 2'b00) && !tx_accept
  ) else $error("disabled status wrong");

  a_write_no_clear: assert property (
    reg_wr && !reg_rd && (reg_addr == IFC_OFS_CLR_GENERAL_CALL_IRQ) && st.irq[IFC_IRQ_GENERAL_CALL_IRQ] && !idle_off
    |=> unmasked_irq_status[IFC_IRQ_GENERAL_CALL_IRQ]
  ) else $error("write cleared an irq");

endmodule

// >>> ifc_link_model.sv
`timescale 1ns/10ps
module ifc_link_model (
  output logic scl_pin,
  output logic sda_pin
);
  localparam time HALF = 400ns;

  // Both lines have pull-ups, so the released and idle level is high.
  initial begin
    scl_pin = 1'b1;
    sda_pin = 1'b1;
  end

  // A start is a data fall while the clock is high.
  task automatic start_frame();
    sda_pin = 1'b0;
    #(HALF);
    scl_pin = 1'b0;
  endtask

  // Data changes only while the clock is low, and the clock stands still low afterwards.
  task automatic send_bits(input int n);
    for (int i = 0; i < n; i++) begin
      sda_pin = i[0];
      #(HALF);
      scl_pin = 1'b1;
      #(HALF);
      scl_pin = 1'b0;
    end
  endtask

  // A stop is a data rise while the clock is high.
  task automatic stop_frame();
    sda_pin = 1'b0;
    #(HALF);
    scl_pin = 1'b1;
    #(HALF);
    sda_pin = 1'b1;
    #(HALF);
  endtask
endmodule

// >>> ifc_ctrl_tb_top.sv
`timescale 1ns/10ps
module ifc_ctrl_tb_top;
  import ifc_pkg::*;
  logic                 sys_clk = 1'b0;
  logic                 rst_n;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [7:0]           reg_addr;
  logic [31:0]          reg_wdata;
  logic [31:0]          reg_rdata;
  logic                 scl_pin;
  logic                 sda_pin;
  ifc_evt_t             evt;
  logic                 tx_accept;
  logic                 ctrl_enabled;
  logic                 nack_last_byte;
  logic                 abort_request;
  logic [IFC_IRQ_W-1:0] irq;
  logic [31:0]          abort_cause_reg;
  logic [6:0]           tx_entry_count;
  logic [6:0]           rx_entry_count;
  int                   fails = 0;
  int                   total_checks = 0;

  always #50 sys_clk = ~sys_clk;

  ifc_link_model i_link (.scl_pin(scl_pin), .sda_pin(sda_pin));

  ifc_ctrl i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .scl_pin(scl_pin), .sda_pin(sda_pin), .evt(evt), .tx_accept(tx_accept),
    .ctrl_enabled(ctrl_enabled), .nack_last_byte(nack_last_byte),
    .abort_request(abort_request), .unmasked_irq_status(irq),
    .abort_cause_reg(abort_cause_reg), .tx_entry_count(tx_entry_count),
    .rx_entry_count(rx_entry_count)
  );

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
  endtask

  task automatic set_ev(input int k, input logic v);
    case (k)
      0: evt.tx_push = v;
      1: evt.rx_push = v;
      2: evt.rx_pop = v;
      3: evt.rd_req = v;
      4: evt.rx_done = v;
      5: evt.general_call_irq = v;
      default: evt.abort = v;
    endcase
  endtask

  // Holds one event for n cycles; the effect is visible when this returns.
  task automatic hold(input int k, input int n);
    @(negedge sys_clk);
    set_ev(k, 1'b1);
    repeat (n) @(negedge sys_clk);
    set_ev(k, 1'b0);
  endtask

  task automatic wait_bit(input int b);
    int n;
    n = 0;
    while (irq[b] !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100) begin
      fails++;
      $display("FAIL at %0t: seen %h expected %h", $time, irq, b);
      end_sim();
    end
  endtask

  // Sets one sticky bit, shows that a write does not clear it, then clears it by a read.
  task automatic clr_case(input int k, input int b, input logic [7:0] ofs);
    hold(k, 1);
    chk(32'(irq[b]), 32'h1);
    wr(ofs, 32'hFFFF_FFFF);
    chk(32'(irq[b]), 32'h1);
    rchk(ofs, 32'h1);
    chk(32'(irq[b]), 32'h0);
  endtask

  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    evt = '0;
    rst_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    rchk(IFC_OFS_STATUS, 32'h6);
    rchk(IFC_OFS_TX_ENTRY_COUNT, 32'h0);
    rchk(IFC_OFS_TX_DRAIN_TRIGGER, 32'h0);
    rchk(8'hFC, 32'h0);
    wr(IFC_OFS_RX_FILL_TRIGGER, 32'h3F);
    rchk(IFC_OFS_RX_FILL_TRIGGER, 32'h3F);
    wr(IFC_OFS_RX_FILL_TRIGGER, 32'hFF);
    rchk(IFC_OFS_RX_FILL_TRIGGER, 32'h40);
    wr(IFC_OFS_TX_DRAIN_TRIGGER, 32'h41);
    rchk(IFC_OFS_TX_DRAIN_TRIGGER, 32'h40);
    wr(IFC_OFS_TX_DRAIN_TRIGGER, 32'h2);
    wr(IFC_OFS_RX_FILL_TRIGGER, 32'h1);
    wr(IFC_OFS_ENABLE, 32'h1);
    hold(0, 2);
    chk(32'(irq[IFC_IRQ_TX_EMPTY]), 32'h1);
    hold(0, 1);
    chk(32'(irq[IFC_IRQ_TX_EMPTY]), 32'h0);
    wr(IFC_OFS_TX_ENTRY_COUNT, 32'h7F);
    rchk(IFC_OFS_TX_ENTRY_COUNT, 32'h3);
    rchk(IFC_OFS_STATUS, 32'h2);
    hold(1, 1);
    chk(32'(irq[IFC_IRQ_RX_FULL]), 32'h0);
    hold(1, 1);
    chk(32'(irq[IFC_IRQ_RX_FULL]), 32'h1);
    hold(1, 62);
    hold(0, 61);
    rchk(IFC_OFS_STATUS, 32'h18);
    clr_case(0, IFC_IRQ_TX_OVER, IFC_OFS_CLR_TX_OVER);
    clr_case(1, IFC_IRQ_RX_OVER, IFC_OFS_CLR_RX_OVER);
    clr_case(3, IFC_IRQ_RD_REQ, IFC_OFS_CLR_RD_REQ);
    clr_case(4, IFC_IRQ_RX_DONE, IFC_OFS_CLR_RX_DONE);
    clr_case(5, IFC_IRQ_GENERAL_CALL_IRQ, IFC_OFS_CLR_GENERAL_CALL_IRQ);
    hold(2, 64);
    clr_case(2, IFC_IRQ_RX_UNDER, IFC_OFS_CLR_RX_UNDER);
    evt.abort_why = 17'h00005;
    hold(6, 1);
    evt.abort_why = '0;
    chk(abort_cause_reg, 32'h5);
    chk({tx_entry_count, tx_accept}, 8'h0);
    rchk(IFC_OFS_CLR_TX_ABORT, 32'h1);
    chk({abort_cause_reg[7:0], tx_accept}, 9'h1);
    evt.sbyte_cond = 1'b1;
    evt.abort_why = 17'h00200;
    hold(6, 1);
    evt.abort_why = '0;
    hold(3, 1);
    rchk(IFC_OFS_CLR_ALL, 32'h1);
    chk(32'(irq), 32'h010);
    chk(abort_cause_reg, 32'h0);
    @(negedge sys_clk);
    chk(abort_cause_reg, 32'h200);
    evt.sbyte_cond = 1'b0;
    rchk(IFC_OFS_CLR_TX_ABORT, 32'h0);
    chk(abort_cause_reg, 32'h0);
    i_link.start_frame();
    wait_bit(IFC_IRQ_START);
    chk(32'(irq[IFC_IRQ_ACTIVITY]), 32'h1);
    rchk(IFC_OFS_STATUS, 32'h7);
    wr(IFC_OFS_ENABLE, 32'h3);
    chk(32'(abort_request), 32'h1);
    i_link.send_bits(9);
    rchk(IFC_OFS_CLR_ACTIVITY, 32'h1);
    chk(32'(irq[IFC_IRQ_ACTIVITY]), 32'h1);
    i_link.stop_frame();
    wait_bit(IFC_IRQ_STOP);
    chk(32'(abort_request), 32'h0);
    rchk(IFC_OFS_ENABLE, 32'h1);
    rchk(IFC_OFS_CLR_STOP, 32'h1);
    rchk(IFC_OFS_CLR_START, 32'h1);
    rchk(IFC_OFS_CLR_ACTIVITY, 32'h1);
    chk(32'(irq[IFC_IRQ_START:IFC_IRQ_ACTIVITY]), 32'h0);
    hold(1, 3);
    evt.master_busy = 1'b1;
    hold(5, 1);
    wr(IFC_OFS_ENABLE, 32'h0);
    chk({rx_entry_count, nack_last_byte}, 8'h1);
    chk(32'(irq[IFC_IRQ_GENERAL_CALL_IRQ]), 32'h1);
    rchk(IFC_OFS_STATUS, 32'h27);
    evt.master_busy = 1'b0;
    @(negedge sys_clk);
    chk(32'(irq), 32'h0);
    rchk(IFC_OFS_STATUS, 32'h6);
    end_sim();
  end
endmodule
